// *** inc/tie_pkg.sv ***
package tie_pkg;

   // ----------------------------------------
   // Register bus geometry
   // ----------------------------------------
   localparam int unsigned ADDR_W = 12;
   localparam int unsigned DATA_W = 8;

   // ----------------------------------------
   // Register offsets
   // ----------------------------------------
   localparam logic [11:0] SYS_EN_ADDR   = 12'h010;
   localparam logic [11:0] CAN_EN_ADDR   = 12'h011;
   localparam logic [11:0] PIN_EN_ADDR   = 12'h012;
   localparam logic [11:0] SYS_STAT_ADDR = 12'h060;

   // ----------------------------------------
   // Field positions (enables share the status positions)
   // ----------------------------------------
   localparam int unsigned BIT_STARTUP   = 7;
   localparam int unsigned BIT_BUS_WAKE  = 6;
   localparam int unsigned BIT_THERMAL   = 5;
   localparam int unsigned BIT_SERIAL    = 4;
   localparam int unsigned BIT_SUPPLY    = 3;
   localparam int unsigned BIT_WAKE_RISE = 1;
   localparam int unsigned BIT_WAKE_FALL = 0;
   localparam int unsigned BIT_SILENCE   = 3;
   localparam int unsigned BIT_STUCK     = 2;
   localparam int unsigned BIT_TX_IN2    = 1;
   localparam int unsigned BIT_TX_IN     = 0;
   localparam int unsigned BIT_PIN2      = 1;
   localparam int unsigned BIT_PIN1      = 0;

   // ----------------------------------------
   // Values after startup and field masks
   // ----------------------------------------
   localparam logic [7:0] SYS_EN_RST    = 8'h08;
   localparam logic [7:0] CAN_EN_RST    = 8'h00;
   localparam logic [7:0] PIN_EN_RST    = 8'h00;
   localparam logic [7:0] SYS_STAT_RST  = 8'h80;
   localparam logic [7:0] SYS_EN_MASK   = 8'h7b;
   localparam logic [7:0] CAN_EN_MASK   = 8'h0f;
   localparam logic [7:0] PIN_EN_MASK   = 8'h03;
   localparam logic [7:0] SYS_STAT_MASK = 8'hfb;
   localparam logic [7:0] WAKE_MASK     = 8'h43;
   localparam logic [7:0] FAILSAFE_SET  = 8'h43;
   localparam logic [1:0] SYNC_PRIMED   = 2'h3;

   // ----------------------------------------
   // Carriers
   // ----------------------------------------
   typedef struct packed {
      logic [11:0] addr;
      logic [7:0]  wdata;
      logic        wr;
      logic        rd;
   } tie_bus_req_type;

   typedef struct packed {
      logic bus_wake;
      logic thermal_warn;
      logic serial_fail;
      logic supply_low;
   } tie_events_type;

   typedef struct packed {
      logic       s1;
      logic       s2;
      logic       prev;
      logic [1:0] primed;
      logic       rise;
      logic       fall;
   } tie_sync_type;

   typedef struct packed {
      logic [7:0] sys_en;
      logic [7:0] can_en;
      logic [7:0] pin_en;
      logic [7:0] sys_stat;
      logic [7:0] rdata;
      logic       failsafe_prev;
      logic       irq;
      logic       wake_req;
   } tie_state_type;

endpackage

// *** design/tie_pin_sync.sv ***
`timescale 1ns/1ns
module tie_pin_sync (
   input  wire logic ref_clk_in,
   input  wire logic reset_in,
   input  wire logic pin_in,
   output logic      rise_out,
   output logic      fall_out
);

   // ----------------------------------------
   // State
   // ----------------------------------------
   tie_pkg::tie_sync_type sync_q;   // Registered state
   tie_pkg::tie_sync_type sync_d;   // Next state

   // Edge pulses come straight from flops
   assign rise_out = sync_q.rise;
   assign fall_out = sync_q.fall;

   // Two flops, then edge compare on the settled copy only.
   // Edges are held off until prev is valid, so a pin that is
   // high at reset release does not look like a rising edge.
   always_comb
   begin
      sync_d        = sync_q;
      sync_d.s1     = pin_in;
      sync_d.s2     = sync_q.s1;
      sync_d.prev   = sync_q.s2;
      if (sync_q.primed != tie_pkg::SYNC_PRIMED)
      begin
         sync_d.primed = sync_q.primed + 2'h1;
      end
      sync_d.rise = (sync_q.primed == tie_pkg::SYNC_PRIMED)
                    && sync_q.s2 && !sync_q.prev;
      sync_d.fall = (sync_q.primed == tie_pkg::SYNC_PRIMED)
                    && !sync_q.s2 && sync_q.prev;
   end

   // Register the copy
   always_ff @(posedge ref_clk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         sync_q <= '0;
      end
      else
      begin
         sync_q <= sync_d;
      end
   end

endmodule

// *** design/tie_irq_regs.sv ***
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ns
// Overview of operation
// RULE1 - Serial failure enable resets clear, gates interrupt
// RULE2 - Supply-low enable resets set, software writable
// RULE3 - Wake rising-edge enable, resets clear
// RULE4 - Wake falling-edge enable, resets clear
// RULE5 - Failsafe entry forces bus and wake enables
// RULE6 - Software writes zero to reserved enable bits
// RULE7 - Bus silence enable at bit three
// RULE8 - Bus stuck-dominant enable at bit two
// RULE9 - Second transmit timeout enable at bit one
// RULE10 - Primary transmit timeout enable at bit zero
// RULE11 - Software writes zeros to upper four bits
// RULE12 - Software selects wake-capable pin function first
// RULE13 - Second pin enable at bit one
// RULE14 - First pin enable at bit zero
// RULE15 - Startup flag set at reset, write-one clears
// RULE16 - Bus wake flag at bit six
// RULE17 - Thermal warning flag at bit five
// RULE18 - Serial failure flag at bit four
// RULE19 - Supply-low flag at bit three
// RULE20 - Software writes one to reserved bit two
// RULE21 - Startup flag always raises the interrupt
// RULE22 - Wake edge flags at bits one, zero
// RULE23 - Interrupt when enabled flag or startup pending
module tie_irq_regs (
   input  wire logic                     ref_clk_in,
   input  wire logic                     reset_in,
   input  wire tie_pkg::tie_bus_req_type bus_req_in,
   output logic [7:0]                    rd_data_out,
   input  wire tie_pkg::tie_events_type  events_in,
   input  wire logic                     wake_pin_in,
   input  wire logic                     failsafe_state_in,
   output logic                          irq_out,
   output logic                          wake_req_out,
   output logic [7:0]                    sys_irq_en_out,
   output logic [3:0]                    can_irq_en_out,
   output logic [1:0]                    pin_irq_en_out
);

   // ----------------------------------------
   // State and helpers
   // ----------------------------------------
   tie_pkg::tie_state_type state_q;     // Registered state
   tie_pkg::tie_state_type state_d;     // Next state
   logic                   wake_rise;   // Synchronised rising edge
   logic                   wake_fall;   // Synchronised falling edge
   logic                   wr_sys_en;   // Write hits system enables
   logic                   wr_can_en;   // Write hits bus enables
   logic                   wr_pin_en;   // Write hits pin enables
   logic                   wr_stat;     // Write hits status
   logic                   fs_entry;    // One cycle on failsafe entry
   logic [7:0]             stat_set;    // Hardware set requests
   logic [7:0]             stat_clr;    // Software clear requests
   logic [7:0]             stat_live;   // Status after set and clear
   logic [7:0]             en_live;     // Enables after this cycle

   // ----------------------------------------
   // Outputs straight from flops
   // ----------------------------------------
   assign rd_data_out    = state_q.rdata;
   assign irq_out        = state_q.irq;
   assign wake_req_out   = state_q.wake_req;
   assign sys_irq_en_out = state_q.sys_en;
   assign can_irq_en_out = state_q.can_en[3:0];
   assign pin_irq_en_out = state_q.pin_en[1:0];

   // ----------------------------------------
   // Wake pin synchroniser
   // ----------------------------------------
   // The wake pin is asynchronous; it is brought in through two
   // flops and turned into single-cycle edge pulses.
   tie_pin_sync u_wake_sync (
      .ref_clk_in (ref_clk_in),
      .reset_in   (reset_in),
      .pin_in     (wake_pin_in),
      .rise_out   (wake_rise),
      .fall_out   (wake_fall)
   );

   // ----------------------------------------
   // Address decode
   // ----------------------------------------
   // Only writes are decoded here; reads are decoded in the
   // read-back mux below.
   always_comb
   begin
      wr_sys_en = bus_req_in.wr
                  && (bus_req_in.addr == tie_pkg::SYS_EN_ADDR);
      wr_can_en = bus_req_in.wr
                  && (bus_req_in.addr == tie_pkg::CAN_EN_ADDR);
      wr_pin_en = bus_req_in.wr
                  && (bus_req_in.addr == tie_pkg::PIN_EN_ADDR);
      wr_stat   = bus_req_in.wr
                  && (bus_req_in.addr == tie_pkg::SYS_STAT_ADDR);
   end

   // ----------------------------------------
   // Failsafe entry
   // ----------------------------------------
   // The failsafe level comes from logic on this clock, so it is
   // used as is. Only the entry forces enables; staying in the
   // state leaves software free to change them again.
   assign fs_entry = failsafe_state_in && !state_q.failsafe_prev;

   // ----------------------------------------
   // Status set and clear requests
   // ----------------------------------------
   always_comb
   begin
      // Default: nothing to set
      stat_set = 8'h00;

      // Bus wake-up event
      stat_set[tie_pkg::BIT_BUS_WAKE] = events_in.bus_wake;     // [RULE16]

      // Thermal warning event
      stat_set[tie_pkg::BIT_THERMAL] = events_in.thermal_warn;  // [RULE17]

      // Serial interface failure
      stat_set[tie_pkg::BIT_SERIAL] = events_in.serial_fail;    // [RULE18]

      // Supply undervoltage
      stat_set[tie_pkg::BIT_SUPPLY] = events_in.supply_low;     // [RULE19]

      // Wake pin edges
      stat_set[tie_pkg::BIT_WAKE_RISE] = wake_rise;             // [RULE22]
      stat_set[tie_pkg::BIT_WAKE_FALL] = wake_fall;             // [RULE22]

      // Write-one clears; reserved bit two is ignored even though
      // software writes a one there
      stat_clr = 8'h00;
      if (wr_stat)
      begin
         stat_clr = bus_req_in.wdata & tie_pkg::SYS_STAT_MASK;  // [RULE20]
      end
   end

   // ----------------------------------------
   // Next-state logic
   // ----------------------------------------
   always_comb
   begin
      // Hold everything by default
      state_d = state_q;

      // Track the failsafe level for entry detection
      state_d.failsafe_prev = failsafe_state_in;

      // System enables: reserved bits stay zero whatever is
      // written, so a careless write cannot create stray enables
      if (wr_sys_en)
      begin
         // Bus wake-up enable
         state_d.sys_en[tie_pkg::BIT_BUS_WAKE] =
            bus_req_in.wdata[tie_pkg::BIT_BUS_WAKE];

         // Thermal warning enable
         state_d.sys_en[tie_pkg::BIT_THERMAL] =
            bus_req_in.wdata[tie_pkg::BIT_THERMAL];

         // Serial failure enable
         state_d.sys_en[tie_pkg::BIT_SERIAL] =
            bus_req_in.wdata[tie_pkg::BIT_SERIAL];         // [RULE1]

         // Supply-low enable, may be turned off and on
         state_d.sys_en[tie_pkg::BIT_SUPPLY] =
            bus_req_in.wdata[tie_pkg::BIT_SUPPLY];         // [RULE2]

         // Wake rising-edge enable
         state_d.sys_en[tie_pkg::BIT_WAKE_RISE] =
            bus_req_in.wdata[tie_pkg::BIT_WAKE_RISE];      // [RULE3]

         // Wake falling-edge enable
         state_d.sys_en[tie_pkg::BIT_WAKE_FALL] =
            bus_req_in.wdata[tie_pkg::BIT_WAKE_FALL];      // [RULE4]

         // Reserved bits seven and two
         state_d.sys_en = state_d.sys_en & tie_pkg::SYS_EN_MASK; // [RULE6]
      end

      // Failsafe entry wins over a software write in the same
      // cycle, so the safe configuration is never lost
      if (fs_entry)
      begin
         state_d.sys_en = state_d.sys_en | tie_pkg::FAILSAFE_SET; // [RULE5]
      end

      // Bus event enables
      if (wr_can_en)
      begin
         // Bus silence
         state_d.can_en[tie_pkg::BIT_SILENCE] =
            bus_req_in.wdata[tie_pkg::BIT_SILENCE];        // [RULE7]

         // Bus stuck dominant
         state_d.can_en[tie_pkg::BIT_STUCK] =
            bus_req_in.wdata[tie_pkg::BIT_STUCK];          // [RULE8]

         // Second transmit input timeout
         state_d.can_en[tie_pkg::BIT_TX_IN2] =
            bus_req_in.wdata[tie_pkg::BIT_TX_IN2];         // [RULE9]

         // Primary transmit input timeout
         state_d.can_en[tie_pkg::BIT_TX_IN] =
            bus_req_in.wdata[tie_pkg::BIT_TX_IN];          // [RULE10]

         // Upper nibble is reserved and stays zero
         state_d.can_en = state_d.can_en & tie_pkg::CAN_EN_MASK; // [RULE11]
      end

      // General-purpose pin enables; these only matter once the
      // pin function has been set to a wake-capable code
      if (wr_pin_en)
      begin
         // Second pin
         state_d.pin_en[tie_pkg::BIT_PIN2] =
            bus_req_in.wdata[tie_pkg::BIT_PIN2];           // [RULE13]

         // First pin
         state_d.pin_en[tie_pkg::BIT_PIN1] =
            bus_req_in.wdata[tie_pkg::BIT_PIN1];           // [RULE14]

         // Upper six bits are reserved
         state_d.pin_en = state_d.pin_en & tie_pkg::PIN_EN_MASK; // [RULE14]
      end

      // Status: a set in the same cycle as a clear wins, so no
      // event is ever lost to a racing acknowledge
      state_d.sys_stat = (state_q.sys_stat & ~stat_clr) | stat_set;

      // Startup flag has no hardware set after reset, only clear
      state_d.sys_stat[tie_pkg::BIT_STARTUP] =
         state_q.sys_stat[tie_pkg::BIT_STARTUP]
         && !stat_clr[tie_pkg::BIT_STARTUP];                // [RULE15]

      // Reserved status bit reads zero
      state_d.sys_stat = state_d.sys_stat & tie_pkg::SYS_STAT_MASK;

      // Interrupt from the next state, so the line follows the
      // flags with no extra cycle of delay
      state_d.irq = (|(stat_live & en_live))                // [RULE23]
                    || stat_live[tie_pkg::BIT_STARTUP];     // [RULE21]

      // Wake request whenever a wake-up source is latched
      state_d.wake_req = |(stat_live & tie_pkg::WAKE_MASK); // [RULE22]

      // Read-back: data stands only in the cycle after the read,
      // unmapped offsets answer zero
      state_d.rdata = 8'h00;
      if (bus_req_in.rd)
      begin
         case (bus_req_in.addr)
            // System enables
            tie_pkg::SYS_EN_ADDR:
            begin
               state_d.rdata = state_q.sys_en;
            end

            // Bus event enables
            tie_pkg::CAN_EN_ADDR:
            begin
               state_d.rdata = state_q.can_en;
            end

            // Pin enables
            tie_pkg::PIN_EN_ADDR:
            begin
               state_d.rdata = state_q.pin_en;
            end

            // Latched status
            tie_pkg::SYS_STAT_ADDR:
            begin
               state_d.rdata = state_q.sys_stat;
            end

            // Anything else
            default:
            begin
               state_d.rdata = 8'h00;
            end
         endcase
      end
   end

   // ----------------------------------------
   // Live views for the interrupt term
   // ----------------------------------------
   // Kept apart from the next-state block so that the interrupt
   // equation reads plainly. The startup bit is masked out of the
   // enable view and handled on its own, since it has no enable.
   always_comb
   begin
      stat_live = ((state_q.sys_stat & ~stat_clr) | stat_set)
                  & tie_pkg::SYS_STAT_MASK;

      stat_live[tie_pkg::BIT_STARTUP] =
         state_q.sys_stat[tie_pkg::BIT_STARTUP]
         && !stat_clr[tie_pkg::BIT_STARTUP];

      en_live = state_q.sys_en;
      if (wr_sys_en)
      begin
         en_live = bus_req_in.wdata & tie_pkg::SYS_EN_MASK;
      end

      if (fs_entry)
      begin
         en_live = en_live | tie_pkg::FAILSAFE_SET;         // [RULE5]
      end

      // The startup position carries no enable
      en_live[tie_pkg::BIT_STARTUP] = 1'b0;
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   // Reset loads the startup values: supply-low enable on, all
   // other enables off, only the startup flag pending. The
   // interrupt flop starts high because that flag is pending.
   always_ff @(posedge ref_clk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         state_q               <= '0;
         state_q.sys_en        <= tie_pkg::SYS_EN_RST;      // [RULE1] [RULE2]
         state_q.can_en        <= tie_pkg::CAN_EN_RST;      // [RULE7]
         state_q.pin_en        <= tie_pkg::PIN_EN_RST;      // [RULE13]
         state_q.sys_stat      <= tie_pkg::SYS_STAT_RST;    // [RULE15]

         state_q.irq           <= 1'b1;                     // [RULE21]
      end
      else
      begin
         state_q <= state_d;
      end
   end

endmodule

// *** testbench/tie_irq_regs_chk.sv ***
`timescale 1ns/1ns
// Port checker for the interrupt enable and status block
module tie_irq_regs_chk (
   input  wire logic                     ref_clk_in,
   input  wire logic                     reset_in,
   input  wire tie_pkg::tie_bus_req_type bus_req_in,
   input  wire logic [7:0]               rd_data_out,
   input  wire tie_pkg::tie_events_type  events_in,
   input  wire logic                     wake_pin_in,
   input  wire logic                     failsafe_state_in,
   input  wire logic                     irq_out,
   input  wire logic                     wake_req_out,
   input  wire logic [7:0]               sys_irq_en_out,
   input  wire logic [3:0]               can_irq_en_out,
   input  wire logic [1:0]               pin_irq_en_out
);
   // ----------------------------------------
   // Helper logic
   // ----------------------------------------
   logic fs_prev_q;  // Failsafe level one edge ago, low out of reset
   logic fs_entry;   // Entry edge into failsafe
   logic sys_wr;     // Write to the system enable register

   // Previous failsafe level; reset low so a level held through reset counts as entry
   always_ff @(posedge ref_clk_in or posedge reset_in)
   begin
      if (reset_in)
         fs_prev_q <= 1'b0;
      else
         fs_prev_q <= failsafe_state_in;
   end

   assign fs_entry = failsafe_state_in & ~fs_prev_q;
   assign sys_wr   = bus_req_in.wr & (bus_req_in.addr == tie_pkg::SYS_EN_ADDR);

   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (reset_in);

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   sys_en_write_a : assert property (sys_wr && !fs_entry |=>
      sys_irq_en_out == ($past(bus_req_in.wdata) & 8'h7b)) else $error("system enable write lost");
   sys_en_hold_a : assert property (!sys_wr && !fs_entry |=> $stable(sys_irq_en_out))
      else $error("system enable changed without cause");
   failsafe_force_a : assert property (fs_entry |=> (sys_irq_en_out & 8'h43) == 8'h43)
      else $error("failsafe entry did not force enables");
   can_en_write_a : assert property (bus_req_in.wr && bus_req_in.addr == 12'h011 |=>
      can_irq_en_out == $past(bus_req_in.wdata[3:0])) else $error("bus enable write lost");
   pin_en_write_a : assert property (bus_req_in.wr && bus_req_in.addr == 12'h012 |=>
      pin_irq_en_out == $past(bus_req_in.wdata[1:0])) else $error("pin enable write lost");
   sys_en_read_a : assert property ($past(bus_req_in.rd) && $past(bus_req_in.addr) == 12'h010
      |-> rd_data_out == $past(sys_irq_en_out)) else $error("system enable read wrong");
   can_en_read_a : assert property ($past(bus_req_in.rd) && $past(bus_req_in.addr) == 12'h011
      |-> rd_data_out == {4'h0, $past(can_irq_en_out)}) else $error("bus enable read wrong");
   startup_irq_a : assert property ($past(bus_req_in.rd) && $past(bus_req_in.addr) == 12'h060
      && rd_data_out[7] |-> irq_out) else $error("startup flag without interrupt");
   wake_req_a : assert property ($past(bus_req_in.rd) && $past(bus_req_in.addr) == 12'h060
      && (rd_data_out & 8'h43) != 8'h00 |-> wake_req_out) else $error("wake flag without request");
   event_irq_a : assert property (!bus_req_in.wr && (events_in & sys_irq_en_out[6:3]) != 4'h0
      |=> irq_out) else $error("enabled event without interrupt");
endmodule

bind tie_irq_regs tie_irq_regs_chk u_chk (
   .ref_clk_in        (ref_clk_in),
   .reset_in          (reset_in),
   .bus_req_in        (bus_req_in),
   .rd_data_out       (rd_data_out),
   .events_in         (events_in),
   .wake_pin_in       (wake_pin_in),
   .failsafe_state_in (failsafe_state_in),
   .irq_out           (irq_out),
   .wake_req_out      (wake_req_out),
   .sys_irq_en_out    (sys_irq_en_out),
   .can_irq_en_out    (can_irq_en_out),
   .pin_irq_en_out    (pin_irq_en_out)
);

// *** testbench/tie_host_model.sv ***
`timescale 1ns/1ns
// Host software model: one register access at a time on the configuration port
module tie_host_model (
   input  wire logic                ref_clk_in,
   input  wire logic [7:0]          rd_data_in,
   output tie_pkg::tie_bus_req_type bus_req_out
);
   // ----------------------------------------
   // Bus access tasks
   // ----------------------------------------
   initial bus_req_out = '0;  // Idle from time zero

   // Write; reserved bits carry what software must send, not the caller's value
   // Pin function is taken as already set to a wake-capable code elsewhere
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      logic [7:0] v;
      begin
         v = d;
         if (a == tie_pkg::SYS_EN_ADDR)
            v = d & 8'h7b;
         if (a == tie_pkg::CAN_EN_ADDR)
            v = d & 8'h0f;
         if (a == tie_pkg::PIN_EN_ADDR)
            v = d & 8'h03;
         if (a == tie_pkg::SYS_STAT_ADDR)
            v = d | 8'h04;
         @(posedge ref_clk_in);
         bus_req_out <= {a, v, 1'b1, 1'b0};
         @(posedge ref_clk_in);
         bus_req_out <= '0;
      end
   endtask

   // Read; data stands only in the cycle after the strobe, so sample it there
   task automatic rd(input logic [11:0] a, output logic [7:0] d);
      begin
         @(posedge ref_clk_in);
         bus_req_out <= {a, 8'h00, 1'b0, 1'b1};
         @(posedge ref_clk_in);
         bus_req_out <= '0;
         #1;
         d = rd_data_in;
      end
   endtask
endmodule

// *** testbench/tb_transceiver_irq_enable_status.sv ***
`timescale 1ns/1ns
// Self-checking bench for the interrupt enable and status block
module tb_transceiver_irq_enable_status;
   // ----------------------------------------
   // Signals and bookkeeping
   // ----------------------------------------
   logic                     ref_clk_in, reset_in, wake_pin, failsafe, irq, wake_req;
   tie_pkg::tie_bus_req_type req;
   tie_pkg::tie_events_type  ev;
   logic [7:0]               rdata, sys_en, got, port;
   logic [3:0]               can_en;
   logic [1:0]               pin_en;
   logic [31:0]              seed;
   logic [11:0]              addrs [4] = '{12'h010, 12'h011, 12'h012, 12'h060};
   logic [7:0]               rsts  [4] = '{8'h08, 8'h00, 8'h00, 8'h80};
   int                       err_count, num_checks, cycles, i;

   tie_irq_regs dut (.ref_clk_in(ref_clk_in), .reset_in(reset_in), .bus_req_in(req),
      .rd_data_out(rdata), .events_in(ev), .wake_pin_in(wake_pin), .failsafe_state_in(failsafe),
      .irq_out(irq), .wake_req_out(wake_req), .sys_irq_en_out(sys_en), .can_irq_en_out(can_en),
      .pin_irq_en_out(pin_en));
   tie_host_model host (.ref_clk_in(ref_clk_in), .rd_data_in(rdata), .bus_req_out(req));

   // ----------------------------------------
   // Clock, timeout, helpers
   // ----------------------------------------
   initial
   begin
      ref_clk_in = 1'b0;
      forever #5 ref_clk_in = ~ref_clk_in;
   end

   // Whole run is under two hundred cycles; the ceiling leaves ample margin
   always @(posedge ref_clk_in)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         err_count++;
         report_and_stop();
      end
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // Enable value expected back: only the documented fields hold
   function automatic logic [7:0] exp_en(input logic [11:0] a, input logic [7:0] d);
      return (a == 12'h010) ? (d & 8'h7b) : (a == 12'h011) ? (d & 8'h0f) : (d & 8'h03);
   endfunction

   task automatic check_byte(input logic [7:0] g, input logic [7:0] e, input string m);
      num_checks++;
      if (g !== e)
      begin
         err_count++;
         $display("FAIL %0t %s got %h expected %h", $time, m, g, e);
      end
   endtask

   task automatic check_bit(input logic g, input logic e, input string m);
      num_checks++;
      if (g !== e)
      begin
         err_count++;
         $display("FAIL %0t %s got %b expected %b", $time, m, g, e);
      end
   endtask

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      seed = 32'hd6f26807;
      reset_in = 1'b1;
      wake_pin = 1'b0;
      failsafe = 1'b0;
      ev = '0;
      repeat (10) @(posedge ref_clk_in);
      reset_in <= 1'b0;
      // Startup values, then an unmapped address
      for (i = 0; i < 4; i++)
      begin
         host.rd(addrs[i], got);
         check_byte(got, rsts[i], "startup value");
      end
      check_bit(irq, 1'b1, "startup interrupt");
      host.rd(12'h0ff, got);
      check_byte(got, 8'h00, "unmapped read");
      $display("test startup done");
      // Random enable writes, read back and seen at the ports
      for (i = 0; i < 12; i++)
      begin
         seed = lfsr(seed);
         host.wr(addrs[i % 3], seed[7:0]);
         host.rd(addrs[i % 3], got);
         check_byte(got, exp_en(addrs[i % 3], seed[7:0]), "enable readback");
         port = (i % 3 == 0) ? sys_en : (i % 3 == 1) ? {4'h0, can_en} : {6'h00, pin_en};
         check_byte(port, exp_en(addrs[i % 3], seed[7:0]), "enable port");
      end
      $display("test enables done");
      // Startup flag ignores enables and clears by writing one
      host.wr(12'h010, 8'h00);
      #1;
      check_bit(irq, 1'b1, "startup not maskable");
      host.wr(12'h060, 8'h80);
      host.rd(12'h060, got);
      check_byte(got, 8'h00, "startup cleared");
      check_bit(irq, 1'b0, "interrupt released");
      // Each event latched with its enable on, then off
      for (i = 0; i < 8; i++)
      begin
         host.wr(12'h010, (i < 4) ? 8'(8'h08 << i) : 8'h00);
         @(posedge ref_clk_in);
         ev <= 4'(4'h1 << (i % 4));
         @(posedge ref_clk_in);
         ev <= '0;
         host.rd(12'h060, got);
         check_byte(got, 8'(8'h08 << (i % 4)), "event latched");
         check_bit(irq, i < 4, "event interrupt gated");
         host.wr(12'h060, 8'(8'h08 << (i % 4)));
         host.rd(12'h060, got);
         check_byte(got, 8'h00, "event cleared");
      end
      $display("test events done");
      // Wake pin edges: four edges of latency, wait a little longer
      host.wr(12'h010, 8'h03);
      @(posedge ref_clk_in);
      wake_pin <= 1'b1;
      repeat (6) @(posedge ref_clk_in);
      host.rd(12'h060, got);
      check_byte(got, 8'h02, "rising edge flag");
      check_bit(irq, 1'b1, "rising edge interrupt");
      @(posedge ref_clk_in);
      wake_pin <= 1'b0;
      repeat (6) @(posedge ref_clk_in);
      host.rd(12'h060, got);
      check_byte(got, 8'h03, "falling edge flag");
      check_bit(wake_req, 1'b1, "wake request");
      host.wr(12'h060, 8'h03);
      host.rd(12'h060, got);
      check_byte(got, 8'h00, "wake flags cleared");
      check_bit(irq, 1'b0, "wake interrupt released");
      $display("test wake done");
      // Failsafe entry forces enables; a later write still takes effect
      host.wr(12'h010, 8'h00);
      @(posedge ref_clk_in);
      failsafe <= 1'b1;
      repeat (2) @(posedge ref_clk_in);
      #1;
      check_byte(sys_en, 8'h43, "failsafe force");
      host.wr(12'h010, 8'h08);
      host.rd(12'h010, got);
      check_byte(got, 8'h08, "write in failsafe");
      @(posedge ref_clk_in);
      failsafe <= 1'b0;
      $display("test failsafe done");
      report_and_stop();
   end
endmodule
